// file: rtl/cebf_pkg.sv
package cebf_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_CFG    = 8'h00;
  localparam logic [7:0] OFS_BUFORG = 8'h04;
  localparam logic [7:0] OFS_NEV    = 8'h08;
  localparam logic [7:0] OFS_RECLEN = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_LOST   = 8'h14;

  // ****************************************
  // Widths and layout
  // ****************************************
  localparam int SMP_W      = 12;
  localparam int NEV_W      = 10;
  localparam int UNITS_W    = 8;
  localparam int NB_W       = 4;
  localparam int LOC_W      = 128;
  localparam int LANE_W     = 16;
  localparam int SIZE_W     = 22;
  localparam int LOST_W     = 16;
  localparam int STAT_BUSYW = 16;
  localparam int STAT_BUSYR = 17;
  localparam int STAT_FULL  = 18;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [31:0]        CFG_RST     = 32'h0000_0040;
  localparam logic [NB_W-1:0]    NB_RST      = 4'h0;
  localparam logic [NEV_W-1:0]   NEV_RST     = 10'h001;
  localparam logic [UNITS_W-1:0] UNITS_RST   = 8'h00;
  localparam logic [2:0]         AP_BASELINE = 3'h1;
  localparam logic [2:0]         P3_EXT      = 3'h0;
  localparam logic [2:0]         P_OVER      = 3'h1;
  localparam logic [2:0]         P3_SHAPED   = 3'h2;
  localparam logic [2:0]         P3_WIN      = 3'h3;
  localparam logic [2:0]         P4_VALID    = 3'h2;
  localparam logic [2:0]         P4_HOLD     = 3'h3;
  localparam logic [2:0]         P_COINC     = 3'h5;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [17:0] unused;
    logic [2:0]  fourth_probe_select;
    logic [2:0]  third_probe_select;
    logic        acq_run;
    logic        format_word_present;
    logic        trigger_mode_flag;
    logic        baseline_enable;
    logic        time_tag_enable;
    logic        charge_enable;
    logic        dual_trace_enable;
    logic        waveform_enable;
  } cebf_cfg_t;

  typedef struct packed {
    logic [SMP_W-1:0] sample;
    logic [SMP_W-1:0] baseline;
    logic             trigger;
    logic             gate;
    logic             ext_trg;
    logic             over_thr;
    logic             shaped_trg;
    logic             val_win;
    logic             coinc;
    logic             validation;
    logic             holdoff;
  } cebf_smp_t;

  typedef struct packed {
    logic [15:0] baseline_word;
    logic [15:0] charge;
  } cebf_q_t;

  typedef struct packed {
    logic dual_trace_enable;
    logic charge_enable;
    logic time_tag_enable;
    logic baseline_enable;
    logic waveform_enable;
    logic trigger_mode_flag;
    logic [2:0] analog_probe_select;
    logic [2:0] fourth_probe_select;
    logic [2:0] third_probe_select;
    logic [16:0] samples_div8;
  } cebf_fmt_t;

  typedef enum logic [1:0] {W_IDLE, W_WAVE, W_Q} cebf_wst_t;
  typedef enum logic [2:0] {R_IDLE, R_HDR0, R_HDR1, R_FETCH, R_EMIT} cebf_rst_t;

endpackage

// file: rtl/cebf_top.sv
// Behaviour
// [RULE1] Memory splits into two-to-the buffer_count_log2 buffers.
// [RULE2] An aggregate never holds more than 1023 events.
// [RULE3] With waveform on, samples per event are eight times record_length_units.
// [RULE4] Each memory location is 128 bits wide.
// [RULE5] Event uses tag location, charge location, plus one location per eight samples.
// [RULE6] List-only events are exactly two locations: tag and charge-baseline.
// [RULE7] A buffer is not read out until it holds all its events.
// [RULE8] Single-event buffers become readable at once; acquisition moves to next buffer.
// [RULE9] Configuration selects mode and fields; with record length it sets event size.
// [RULE10] Aggregate is a header then its events; first word gives size in words.
// [RULE11] First header word carries format_word_present; when set, second word is format.
// [RULE12] Format word reports the six enable flags, one when enabled.
// [RULE13] Format word carries probe selections and samples divided by eight.
// [RULE14] Analog probe field always reports the baseline.
// [RULE15] Third probe codes: external, over threshold, shaped, window, coincidence.
// [RULE16] Fourth probe codes: over threshold, validation, hold-off, coincidence.
// [RULE17] Every sample carries four digital probe bits.
// [RULE18] First probe bit is trigger, second is gate, others the selected probes.
// [RULE19] Even samples hold input, or next-time baseline when dual trace on.
// [RULE20] Odd samples always hold the input at their own time.
// [RULE21] Each event ends with charge and frozen baseline word.
// [RULE22] Event order: tag, waveform ascending, then charge-baseline.
// [RULE23] Waveform word packs two samples, even sample in low half.
module cebf_top
  import cebf_pkg::*;
#(
  parameter int MEM_AW = 12
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic             trig_valid,
  input  wire logic [31:0]      time_tag,
  input  wire logic             smp_valid,
  input  wire cebf_smp_t        smp_in,
  input  wire logic             q_valid,
  input  wire cebf_q_t          q_in,
  output logic                  out_valid,
  output logic      [31:0]      out_data,
  output logic                  out_last,
  input  wire logic             out_ready,
  output logic                  buf_avail
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    cebf_cfg_t          cfg;
    logic [NB_W-1:0]    nb;
    logic [NEV_W-1:0]   nev;
    logic [UNITS_W-1:0] units;
    logic               dph_wr;
    logic               dph_rd;
    logic [7:0]         dph_addr;
    logic               hreadyout;
    logic [31:0]        hrdata;
    logic [LOST_W-1:0]  lost;
    cebf_wst_t          wr_st;
    logic [MEM_AW-1:0]  wb;
    logic [MEM_AW-1:0]  woff;
    logic [NEV_W-1:0]   wev;
    logic [UNITS_W+2:0] sidx;
    logic [LOC_W-1:0]   asm;
    logic [LANE_W-1:0]  even_hold;
    logic [MEM_AW:0]    filled;
    cebf_rst_t          rd_st;
    logic [MEM_AW-1:0]  rb;
    logic [MEM_AW-1:0]  rloc;
    logic [UNITS_W:0]   rli;
    logic [1:0]         rword;
    logic               out_valid;
    logic [31:0]        out_data;
    logic               out_last;
    logic               avail;
  } cebf_state_t;
  cebf_state_t              s_r;
  cebf_state_t              s_nxt;
  logic [LOC_W-1:0]         mem [2**MEM_AW];
  logic [LOC_W-1:0]         mem_q;
  logic                     mem_we;
  logic [MEM_AW-1:0]        mem_wa;
  logic [LOC_W-1:0]         mem_wd;
  logic [MEM_AW-1:0]        mem_ra;
  logic [MEM_AW:0]          nbuf;
  logic [MEM_AW:0]          bsz;
  logic [NEV_W-1:0]         ne_eff;
  logic                     wave_on;
  logic [UNITS_W:0]         evsz;
  logic [UNITS_W+2:0]       nsmp;
  logic [UNITS_W+2:0]       evw;
  logic [MEM_AW-1:0]        wbase;
  logic [MEM_AW-1:0]        rbase;
  logic                     room;
  logic [NEV_W+UNITS_W:0]   aglocs;
  logic [SIZE_W-1:0]        agsize;
  logic                     out_free;
  logic                     addr_ph;
  logic                     buf_done;
  logic                     buf_read;
  logic [LANE_W-1:0]        lane_new;
  cebf_fmt_t                fmt;
  // ****************************************
  // Probe selection
  // ****************************************
  function automatic logic probe3(input logic [2:0] sel, input cebf_smp_t d);
    case (sel) // RULE15
      P3_EXT:    probe3 = d.ext_trg;
      P_OVER:    probe3 = d.over_thr;
      P3_SHAPED: probe3 = d.shaped_trg;
      P3_WIN:    probe3 = d.val_win;
      P_COINC:   probe3 = d.coinc;
      default:   probe3 = 1'b0;
    endcase
  endfunction
  function automatic logic probe4(input logic [2:0] sel, input cebf_smp_t d);
    case (sel) // RULE16
      P_OVER:   probe4 = d.over_thr;
      P4_VALID: probe4 = d.validation;
      P4_HOLD:  probe4 = d.holdoff;
      P_COINC:  probe4 = d.coinc;
      default:  probe4 = 1'b0;
    endcase
  endfunction
  // ****************************************
  // Geometry
  // ****************************************
  assign nbuf     = (MEM_AW+1)'(1) << s_r.nb; // RULE1
  assign bsz      = (MEM_AW+1)'(1) << (MEM_AW - int'(s_r.nb));
  assign ne_eff   = (s_r.nev == '0) ? NEV_W'(1) : s_r.nev; // RULE2
  assign wave_on  = s_r.cfg.waveform_enable && (s_r.units != '0); // RULE9
  assign evsz     = wave_on ? (UNITS_W+1)'(s_r.units) + (UNITS_W+1)'(2) : (UNITS_W+1)'(2); // RULE5 RULE6
  assign nsmp     = {s_r.units, 3'h0}; // RULE3
  assign evw      = wave_on ? {1'b0, s_r.units, 2'h0} + (UNITS_W+3)'(2) : (UNITS_W+3)'(2);
  assign wbase    = s_r.wb << (MEM_AW - int'(s_r.nb));
  assign rbase    = s_r.rb << (MEM_AW - int'(s_r.nb));
  assign room     = (s_r.filled < nbuf) && (({1'b0, s_r.woff} + (MEM_AW+1)'(evsz)) <= bsz);
  assign aglocs   = (NEV_W+UNITS_W+1)'(ne_eff) * (NEV_W+UNITS_W+1)'(evsz);
  assign agsize   = SIZE_W'(s_r.cfg.format_word_present ? 2 : 1)
                  + SIZE_W'(ne_eff) * SIZE_W'(evw); // RULE10
  assign out_free = !s_r.out_valid || out_ready;
  assign addr_ph  = hsel && htrans[1] && hready;
  assign mem_ra   = rbase + s_r.rloc;
  assign lane_new = {probe4(s_r.cfg.fourth_probe_select, smp_in),
                     probe3(s_r.cfg.third_probe_select, smp_in),
                     smp_in.gate, smp_in.trigger, smp_in.sample}; // RULE17 RULE18
  always_comb begin
    fmt.dual_trace_enable   = s_r.cfg.dual_trace_enable; // RULE12
    fmt.charge_enable       = s_r.cfg.charge_enable;
    fmt.time_tag_enable     = s_r.cfg.time_tag_enable;
    fmt.baseline_enable     = s_r.cfg.baseline_enable;
    fmt.waveform_enable     = s_r.cfg.waveform_enable;
    fmt.trigger_mode_flag   = s_r.cfg.trigger_mode_flag;
    fmt.analog_probe_select = AP_BASELINE; // RULE14
    fmt.fourth_probe_select = s_r.cfg.fourth_probe_select; // RULE13
    fmt.third_probe_select  = s_r.cfg.third_probe_select;
    fmt.samples_div8        = 17'(s_r.units);
  end
  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt    = s_r;
    mem_we   = 1'b0;
    mem_wa   = wbase + s_r.woff;
    mem_wd   = '0;
    buf_done = 1'b0;
    buf_read = 1'b0;
    // Bus slave: writes in data phase, reads take one wait state
    s_nxt.dph_wr   = addr_ph && hwrite;
    s_nxt.dph_rd   = addr_ph && !hwrite;
    s_nxt.dph_addr = haddr[7:0];
    if (addr_ph && !hwrite) begin
      s_nxt.hreadyout = 1'b0;
    end
    if (s_r.dph_rd && !s_r.hreadyout) begin
      s_nxt.hreadyout = 1'b1;
      case (s_r.dph_addr)
        OFS_CFG:    s_nxt.hrdata = s_r.cfg;
        OFS_BUFORG: s_nxt.hrdata = 32'(s_r.nb);
        OFS_NEV:    s_nxt.hrdata = 32'(s_r.nev);
        OFS_RECLEN: s_nxt.hrdata = 32'(s_r.units);
        OFS_STATUS: begin
          s_nxt.hrdata             = 32'(s_r.filled);
          s_nxt.hrdata[STAT_BUSYW] = s_r.wr_st != W_IDLE;
          s_nxt.hrdata[STAT_BUSYR] = s_r.rd_st != R_IDLE;
          s_nxt.hrdata[STAT_FULL]  = s_r.filled == nbuf;
        end
        OFS_LOST:   s_nxt.hrdata = 32'(s_r.lost);
        default:    s_nxt.hrdata = 32'h0000_0000;
      endcase
    end
    if (s_r.dph_wr) begin
      case (s_r.dph_addr)
        OFS_CFG: begin
          s_nxt.cfg        = cebf_cfg_t'(hwdata);
          s_nxt.cfg.unused = '0;
        end
        OFS_BUFORG: s_nxt.nb    = (int'(hwdata[NB_W-1:0]) > MEM_AW) ? NB_W'(MEM_AW) : hwdata[NB_W-1:0];
        OFS_NEV:    s_nxt.nev   = hwdata[NEV_W-1:0]; // RULE2
        OFS_RECLEN: s_nxt.units = hwdata[UNITS_W-1:0];
        OFS_LOST:   s_nxt.lost  = '0;
        default:    s_nxt.lost  = s_nxt.lost;
      endcase
    end
    // Event writer
    case (s_r.wr_st)
      W_IDLE: begin
        if (trig_valid && s_r.cfg.acq_run) begin
          if (room) begin
            mem_we          = 1'b1; // RULE22
            mem_wd          = LOC_W'(time_tag);
            s_nxt.woff      = s_r.woff + MEM_AW'(1);
            s_nxt.sidx      = '0;
            s_nxt.wr_st     = wave_on ? W_WAVE : W_Q; // RULE6
          end else begin
            s_nxt.lost      = s_nxt.lost + LOST_W'(1);
          end
        end
      end
      W_WAVE: begin
        if (smp_valid) begin
          if (!s_r.sidx[0]) begin
            s_nxt.even_hold = lane_new;
          end else begin
            s_nxt.asm[s_r.sidx[2:0]*LANE_W +: LANE_W] = lane_new; // RULE20
            s_nxt.asm[(s_r.sidx[2:0]-3'h1)*LANE_W +: LANE_W] =
              {s_r.even_hold[LANE_W-1:SMP_W],
               s_r.cfg.dual_trace_enable ? smp_in.baseline : s_r.even_hold[SMP_W-1:0]}; // RULE19
          end
          if (s_r.sidx[2:0] == 3'h7) begin
            mem_we     = 1'b1; // RULE4 RULE5
            mem_wd     = s_nxt.asm;
            s_nxt.woff = s_r.woff + MEM_AW'(1);
          end
          s_nxt.sidx = s_r.sidx + (UNITS_W+3)'(1);
          if (s_r.sidx == nsmp - (UNITS_W+3)'(1)) begin
            s_nxt.wr_st = W_Q; // RULE3
          end
        end
      end
      W_Q: begin
        if (q_valid) begin
          mem_we      = 1'b1;
          mem_wd      = LOC_W'(q_in); // RULE21
          s_nxt.woff  = s_r.woff + MEM_AW'(1);
          s_nxt.wev   = s_r.wev + NEV_W'(1);
          s_nxt.wr_st = W_IDLE;
          if (s_r.wev + NEV_W'(1) == ne_eff) begin
            buf_done   = 1'b1; // RULE7 RULE8
            s_nxt.wev  = '0;
            s_nxt.woff = '0;
            s_nxt.wb   = (s_r.wb + MEM_AW'(1)) & MEM_AW'(nbuf - (MEM_AW+1)'(1)); // RULE1
          end
        end
      end
      default: s_nxt.wr_st = W_IDLE;
    endcase
    // Aggregate reader
    if (s_r.out_valid && out_ready) begin
      s_nxt.out_valid = 1'b0;
      s_nxt.out_last  = 1'b0;
    end
    case (s_r.rd_st)
      R_IDLE: begin
        if (s_r.filled != '0) begin
          s_nxt.rd_st = R_HDR0; // RULE7
        end
      end
      R_HDR0: begin
        if (out_free) begin
          s_nxt.out_valid = 1'b1;
          s_nxt.out_data  = {s_r.cfg.format_word_present, 9'h000, agsize}; // RULE10 RULE11
          s_nxt.rloc      = '0;
          s_nxt.rli       = '0;
          s_nxt.rword     = '0;
          s_nxt.rd_st     = s_r.cfg.format_word_present ? R_HDR1 : R_FETCH; // RULE11
        end
      end
      R_HDR1: begin
        if (out_free) begin
          s_nxt.out_valid = 1'b1;
          s_nxt.out_data  = fmt; // RULE12 RULE13
          s_nxt.rd_st     = R_FETCH;
        end
      end
      R_FETCH: s_nxt.rd_st = R_EMIT;
      R_EMIT: begin
        if (out_free) begin
          s_nxt.out_valid = 1'b1;
          if (s_r.rli == '0 || s_r.rli == evsz - (UNITS_W+1)'(1)) begin
            s_nxt.out_data = mem_q[31:0]; // RULE22
          end else begin
            s_nxt.out_data = mem_q[s_r.rword*32 +: 32]; // RULE23
          end
          s_nxt.rword = s_r.rword + 2'h1;
          if (s_r.rli == '0 || s_r.rli == evsz - (UNITS_W+1)'(1) || s_r.rword == 2'h3) begin
            s_nxt.rword = '0;
            s_nxt.rloc  = s_r.rloc + MEM_AW'(1);
            s_nxt.rli   = (s_r.rli == evsz - (UNITS_W+1)'(1)) ? '0 : s_r.rli + (UNITS_W+1)'(1);
            s_nxt.rd_st = R_FETCH;
            if ((NEV_W+UNITS_W+1)'(s_r.rloc) + (NEV_W+UNITS_W+1)'(1) == aglocs) begin
              buf_read       = 1'b1;
              s_nxt.out_last = 1'b1;
              s_nxt.rb       = (s_r.rb + MEM_AW'(1)) & MEM_AW'(nbuf - (MEM_AW+1)'(1));
              s_nxt.rd_st    = R_IDLE;
            end
          end
        end
      end
      default: s_nxt.rd_st = R_IDLE;
    endcase
    s_nxt.filled = s_r.filled + (MEM_AW+1)'(buf_done) - (MEM_AW+1)'(buf_read); // RULE8
    s_nxt.avail  = s_nxt.filled != '0;
  end
  // ****************************************
  // Registers and memory
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r           <= '0;
      s_r.cfg       <= cebf_cfg_t'(CFG_RST);
      s_r.nb        <= NB_RST;
      s_r.nev       <= NEV_RST;
      s_r.units     <= UNITS_RST;
      s_r.hreadyout <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
  always_ff @(posedge hclk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    mem_q <= mem[mem_ra];
  end
  assign hrdata    = s_r.hrdata;
  assign hreadyout = s_r.hreadyout;
  assign hresp     = 1'b0;
  assign out_valid = s_r.out_valid;
  assign out_data  = s_r.out_data;
  assign out_last  = s_r.out_last;
  assign buf_avail = s_r.avail;
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_buf_wrap;
    {1'b0, s_r.wb} < nbuf;
  endproperty
  a_buf_wrap: assert property (p_buf_wrap) else $error("write buffer index beyond buffer count"); // RULE1
  property p_nev_max;
    s_r.wev <= 10'h3FE;
  endproperty
  a_nev_max: assert property (p_nev_max) else $error("aggregate holds over 1023 events"); // RULE2
  sequence s_last_smp;
    s_r.wr_st == W_WAVE && smp_valid && s_r.sidx == nsmp - (UNITS_W+3)'(1);
  endsequence
  property p_smp_count;
    s_last_smp |=> s_r.wr_st == W_Q && s_r.sidx == $past(nsmp);
  endproperty
  a_smp_count: assert property (p_smp_count) else $error("sample count differs from eight per unit"); // RULE3
  property p_list_two;
    s_r.wr_st == W_IDLE && mem_we && !wave_on |=> s_r.wr_st == W_Q;
  endproperty
  a_list_two: assert property (p_list_two) else $error("list event not tag then charge"); // RULE6
  property p_hold;
    s_r.rd_st != R_IDLE |-> s_r.filled != '0;
  endproperty
  a_hold: assert property (p_hold) else $error("readout of an incomplete buffer"); // RULE7
  sequence s_qwrite;
    s_r.wr_st == W_Q && q_valid && ne_eff == NEV_W'(1) && !buf_read;
  endsequence
  property p_single;
    s_qwrite |=> s_r.filled == $past(s_r.filled) + (MEM_AW+1)'(1) ##1 s_r.rd_st != R_IDLE;
  endproperty
  a_single: assert property (p_single) else $error("single event buffer not released"); // RULE8
  property p_fi;
    s_r.rd_st == R_HDR0 && out_free && s_r.cfg.format_word_present |=> s_r.out_data[31] && s_r.rd_st == R_HDR1;
  endproperty
  a_fi: assert property (p_fi) else $error("format word flag or order wrong"); // RULE11
  property p_ap;
    s_r.rd_st == R_HDR1 && out_free |=> s_r.out_data[25:23] == AP_BASELINE;
  endproperty
  a_ap: assert property (p_ap) else $error("analog probe is not baseline"); // RULE14
  property p_dp;
    mem_we && s_r.wr_st == W_WAVE |-> mem_wd[124] == smp_in.trigger && mem_wd[125] == smp_in.gate;
  endproperty
  a_dp: assert property (p_dp) else $error("probe bits not trigger and gate"); // RULE18
endmodule

// file: testbench/cebf_sink.sv
module cebf_sink (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        slow,
  input  wire logic        out_valid,
  input  wire logic [31:0] out_data,
  input  wire logic        out_last,
  output logic             out_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] words[$];
  logic        lasts[$];
  logic        tog_r;

  // ****************************************
  // Stream sink, stalls every other cycle when slow
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tog_r <= 1'b0;
    end else begin
      tog_r <= ~tog_r;
      if (out_valid && out_ready) begin
        words.push_back(out_data);
        lasts.push_back(out_last);
      end
    end
  end

  assign out_ready = hresetn && (!slow || tog_r);
endmodule

// file: testbench/channel_event_buffer_formatter_test.sv
module channel_event_buffer_formatter_test
  import cebf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, slow;
  logic [31:0] haddr, hwdata, hrdata, time_tag, out_data;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, trig_valid, smp_valid, q_valid;
  logic        out_valid, out_last, out_ready, buf_avail;
  cebf_smp_t   smp_in;
  cebf_q_t     q_in;
  logic [31:0] exp_q[$];
  int          err_total;
  int          tests_run;

  always #2 hclk = ~hclk;

  cebf_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .trig_valid(trig_valid), .time_tag(time_tag),
    .smp_valid(smp_valid), .smp_in(smp_in), .q_valid(q_valid), .q_in(q_in),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last), .out_ready(out_ready),
    .buf_avail(buf_avail));

  cebf_sink sink (.hclk(hclk), .hresetn(hresetn), .slow(slow), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .out_ready(out_ready));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
      n++;
      if (n > 50) begin
        err_total++;
        report_and_stop();
      end
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    step();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    step();
    r = hrdata;
  endtask

  function automatic cebf_smp_t smp(input int k);
    cebf_smp_t s;
    s = '0;
    s.sample = 12'h100 + k[11:0];
    s.baseline = 12'h800 + k[11:0];
    s.trigger = k[0];
    s.gate = k[1];
    s.val_win = k[2];
    s.holdoff = ~k[1];
    s.over_thr = ~k[0];
    s.coinc = 1'b1;
    return s;
  endfunction

  function automatic logic [15:0] lane(input int k, input logic base);
    cebf_smp_t s;
    cebf_smp_t t;
    s = smp(k);
    t = smp(k + 1);
    return {s.holdoff, s.val_win, s.gate, s.trigger, base ? t.baseline : s.sample};
  endfunction

  task automatic event_in(input logic [31:0] tag, input int ns);
    trig_valid <= 1'b1;
    time_tag <= tag;
    @(posedge hclk);
    trig_valid <= 1'b0;
    for (int k = 0; k < ns; k++) begin
      smp_valid <= 1'b1;
      smp_in <= smp(k);
      @(posedge hclk);
    end
    smp_valid <= 1'b0;
    q_valid <= 1'b1;
    q_in <= {~tag[15:0], tag[15:0]};
    @(posedge hclk);
    q_valid <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask

  task automatic cmp_stream(input string nm);
    int c;
    c = 0;
    while (sink.words.size() < exp_q.size()) begin
      @(posedge hclk);
      c++;
      if (c > 2000) begin
        err_total++;
        report_and_stop();
      end
    end
    repeat (20) @(posedge hclk);
    check("word count", sink.words.size(), exp_q.size());
    for (int i = 0; i < exp_q.size(); i++) begin
      check("stream word", sink.words[i], exp_q[i]);
      check("last flag", {31'h0, sink.lasts[i]}, {31'h0, i == exp_q.size() - 1});
    end
    sink.words.delete();
    sink.lasts.delete();
    exp_q.delete();
    $display("test %s done", nm);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_regs();
    logic [31:0] r;
    bus(OFS_CFG, 1'b0, 32'h0, r);
    check("cfg reset", r, CFG_RST);
    bus(8'h18, 1'b0, 32'h0, r);
    check("unmapped", r, 32'h0);
    check("okay response", {31'h0, hresp}, 32'h0);
    $display("test regs done");
  endtask

  task automatic test_list();
    logic [31:0] r;
    bus(OFS_BUFORG, 1'b1, 32'h1, r);
    bus(OFS_CFG, 1'b1, 32'hCC, r);
    event_in(32'hA5A5_0001, 0);
    check("single event ready", {31'h0, buf_avail}, 32'h1);
    exp_q.push_back({1'b1, 9'h0, 22'd4});
    exp_q.push_back(cebf_fmt_t'{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, AP_BASELINE, 3'h0, 3'h0, 17'h0});
    exp_q.push_back(32'hA5A5_0001);
    exp_q.push_back(32'hFFFE_0001);
    cmp_stream("list");
  endtask

  task automatic test_wave();
    logic [31:0] r;
    slow = 1'b1;
    bus(OFS_RECLEN, 1'b1, 32'h1, r);
    bus(OFS_NEV, 1'b1, 32'h2, r);
    bus(OFS_CFG, 1'b1, 32'h1BC3, r);
    event_in(32'h5000_0000, 8);
    check("partial buffer held", {31'h0, buf_avail}, 32'h0);
    event_in(32'h5000_0001, 8);
    exp_q.push_back({1'b1, 9'h0, 22'd14});
    exp_q.push_back(cebf_fmt_t'{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, AP_BASELINE, P4_HOLD, P3_WIN, 17'h1});
    for (int e = 0; e < 2; e++) begin
      exp_q.push_back(32'h5000_0000 + e);
      for (int p = 0; p < 4; p++) begin
        exp_q.push_back({lane(2 * p + 1, 1'b0), lane(2 * p, 1'b1)});
      end
      exp_q.push_back({16'hFFFF - e[15:0], 16'h0000 + e[15:0]});
    end
    cmp_stream("wave");
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    trig_valid = 1'b0;
    time_tag = 32'h0;
    smp_valid = 1'b0;
    smp_in = '0;
    q_valid = 1'b0;
    q_in = '0;
    slow = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    test_regs();
    test_list();
    test_wave();
    report_and_stop();
  end
endmodule
